// >>> ccfd_osc_model.sv
// Crystal and slow RC oscillator model feeding the detector clock pins
`timescale 1ns/1ns
module ccfd_osc_model #(
  parameter int XTAL_HALF_NS = 100,
  parameter int SLOW_HALF_NS = 2000
) (
  input wire logic [1:0] xtal_mode,
  input wire logic slow_rc_enable,
  output logic xtal_clk_pin,
  output logic slow_rc_clk_pin
);
  // Crystal: 0 stopped low, 1 nominal, 2 half speed (too few periods per window)
  initial begin
    xtal_clk_pin = 1'b0;
    forever begin
      if (xtal_mode == 2'h0) begin
        xtal_clk_pin = 1'b0;
        #(XTAL_HALF_NS);
      end else begin
        #(XTAL_HALF_NS * xtal_mode);
        xtal_clk_pin = ~xtal_clk_pin;
      end
    end
  end

  // Slow RC runs only while the device enables it, otherwise it stands low
  initial begin
    slow_rc_clk_pin = 1'b0;
    forever begin
      #(SLOW_HALF_NS);
      if (slow_rc_enable === 1'b1) slow_rc_clk_pin = ~slow_rc_clk_pin;
      else slow_rc_clk_pin = 1'b0;
    end
  end
endmodule // ccfd_osc_model

// >>> ccfd_pkg.sv
// Package for the crystal clock failure detector: map, fields, resets, carriers
package ccfd_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] MAIN_OSC_REG_OFS = 8'h00;
  localparam logic [7:0] MASTER_CLK_REG_OFS = 8'h04;
  localparam logic [7:0] POWER_STATUS_REG_OFS = 8'h08;
  localparam logic [7:0] INT_ENABLE_REG_OFS = 8'h0c;
  localparam logic [7:0] FAULT_CLEAR_REG_OFS = 8'h10;
  localparam logic [7:0] INT_CLEAR_REG_OFS = 8'h14;

  // Field positions in the main oscillator register
  localparam int OSC_XTAL_EN_BIT = 0;
  localparam int OSC_RC_EN_BIT = 1;
  localparam int OSC_DET_EN_BIT = 2;
  localparam int OSC_SEL_BIT = 3;

  // Field positions in the status, enable and clear registers
  localparam int SR_EVENT_BIT = 0;
  localparam int SR_FAULT_BIT = 1;
  localparam int SR_STATE_BIT = 2;
  localparam int SR_SLOW_RC_BIT = 3;
  localparam int FAULT_CLEAR_BIT = 0;

  // Master clock source encodings
  localparam logic [1:0] MSRC_SLOW = 2'h0;
  localparam logic [1:0] MSRC_MAIN = 2'h1;
  localparam logic [1:0] MSRC_PLL_A = 2'h2;
  localparam logic [1:0] MSRC_USB_PLL_DIV = 2'h3;

  // Crystal periods needed in one slow RC high phase
  localparam logic [3:0] XTAL_MIN_COUNT = 4'h8;

  // AHB transfer type for a single transfer
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Clock configuration seen by the clock tree
  typedef struct packed {
    logic crystal_osc_enable;
    logic main_rc_enable;
    logic failure_detector_enable;
    logic main_source_select;
    logic [1:0] master_source_select;
  } ccfd_cfg_s;

  localparam ccfd_cfg_s CFG_RESET = '{
    crystal_osc_enable: 1'b0,
    main_rc_enable: 1'b1,
    failure_detector_enable: 1'b0,
    main_source_select: 1'b0,
    master_source_select: MSRC_MAIN
  };

endpackage

// >>> ccfd_top.sv
// Crystal clock failure detector with AHB-Lite registers and clock switchover
`timescale 1ns/1ns
module ccfd_top
  import ccfd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic xtal_clk_pin,
  input wire logic slow_rc_clk_pin,
  output ccfd_cfg_s clk_cfg,
  output logic slow_rc_enable,
  output logic fault_out,
  output logic irq
);

  // Pin synchronisers and edge history
  logic xtal_s1_q, xtal_s2_q, xtal_prev_q;
  logic rc_s1_q, rc_s2_q, rc_prev_q;
  // Detector state
  logic [3:0] cnt_q, cnt_d;
  logic armed_q, armed_d;
  logic verdict_q, verdict_d;
  logic detect_state_q, detect_state_d;
  logic pending_q, pending_d;
  // Software visible state
  ccfd_cfg_s cfg_q, cfg_d;
  logic event_q, event_d;
  logic fault_q, fault_d;
  logic int_en_q, int_en_d;
  logic slow_rc_q;
  // Bus data phase state
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q, rdata_d;

  // Both clocks come from pins, so each passes two flops first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_prev_q <= 1'b0;
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end else begin
      xtal_s1_q <= xtal_clk_pin;
      xtal_s2_q <= xtal_s1_q;
      xtal_prev_q <= xtal_s2_q;
      rc_s1_q <= slow_rc_clk_pin;
      rc_s2_q <= rc_s1_q;
      rc_prev_q <= rc_s2_q;
    end
  end

  // Edge detection on the synchronised levels only
  wire xtal_rise = xtal_s2_q & ~xtal_prev_q;
  wire rc_high = rc_s2_q;
  wire rc_rise = rc_s2_q & ~rc_prev_q;
  wire rc_fall = ~rc_s2_q & rc_prev_q;

  // Detector runs only when enabled and the crystal is on
  wire det_active = cfg_q.failure_detector_enable & cfg_q.crystal_osc_enable;
  wire pll_route = cfg_q.main_source_select &
                   ((cfg_q.master_source_select == MSRC_PLL_A) |
                    (cfg_q.master_source_select == MSRC_USB_PLL_DIV));

  // Counter: cleared while low, counts crystal edges while high, saturates
  assign cnt_d = (!rc_high || !det_active) ? 4'h0 :
                 (xtal_rise && cnt_q != XTAL_MIN_COUNT) ? cnt_q + 4'h1 : cnt_q;

  // Armed once a whole high phase has started under an active detector
  assign armed_d = !det_active ? 1'b0 : (rc_rise ? 1'b1 : armed_q);

  // Verdict taken once per period at the end of the high phase
  assign verdict_d = !det_active ? 1'b0 :
                     (rc_fall && armed_q) ? (cnt_q < XTAL_MIN_COUNT) : verdict_q;

  // Verdict moves to the slow RC rising edge before anything acts on it
  assign detect_state_d = !det_active ? 1'b0 : (rc_rise ? verdict_q : detect_state_q);
  wire fail_pulse = det_active & rc_rise & verdict_q & ~detect_state_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      armed_q <= 1'b0;
      verdict_q <= 1'b0;
      detect_state_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      verdict_q <= verdict_d;
      detect_state_q <= detect_state_d;
    end
  end

  // AHB address phase decode
  wire bus_take = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire rd_take = bus_take & ~hwrite;
  wire wr_take = bus_take & hwrite;
  wire [7:0] addr_lo = haddr[7:0];
  wire rd_status = rd_take & (addr_lo == POWER_STATUS_REG_OFS);

  // Data phase write strobes
  wire wr_osc = wr_pend_q & (wr_addr_q == MAIN_OSC_REG_OFS);
  wire wr_mck = wr_pend_q & (wr_addr_q == MASTER_CLK_REG_OFS);
  wire wr_ie = wr_pend_q & (wr_addr_q == INT_ENABLE_REG_OFS);
  wire wr_fclr = wr_pend_q & (wr_addr_q == FAULT_CLEAR_REG_OFS);
  wire wr_iclr = wr_pend_q & (wr_addr_q == INT_CLEAR_REG_OFS);

  // Software writes first, then the failure mechanism overrides them
  always_comb begin
    cfg_d = cfg_q;
    pending_d = pending_q;
    if (wr_osc) begin
      cfg_d.crystal_osc_enable = hwdata[OSC_XTAL_EN_BIT];
      cfg_d.main_rc_enable = hwdata[OSC_RC_EN_BIT];
      cfg_d.failure_detector_enable = hwdata[OSC_DET_EN_BIT];
      cfg_d.main_source_select = hwdata[OSC_SEL_BIT];
    end
    if (wr_mck) begin
      cfg_d.master_source_select = hwdata[1:0];
    end
    if (fail_pulse && pll_route) begin
      // PLL case moves the master clock first, main source one period later
      cfg_d.master_source_select = MSRC_MAIN;
      pending_d = 1'b1;
    end else if (fail_pulse || (pending_q && rc_rise)) begin
      cfg_d.main_source_select = 1'b0;
      cfg_d.main_rc_enable = 1'b1;
      pending_d = 1'b0;
    end
  end

  // Flags: a hardware set wins over a clear in the same cycle
  assign event_d = fail_pulse ? 1'b1 :
                   ((rd_status || (wr_iclr && hwdata[SR_EVENT_BIT])) ? 1'b0 : event_q);
  assign fault_d = fail_pulse ? 1'b1 :
                   ((wr_fclr && hwdata[FAULT_CLEAR_BIT]) ? 1'b0 : fault_q);
  assign int_en_d = wr_ie ? hwdata[SR_EVENT_BIT] : int_en_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CFG_RESET;
      pending_q <= 1'b0;
      event_q <= 1'b0;
      fault_q <= 1'b0;
      int_en_q <= 1'b0;
      slow_rc_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      pending_q <= pending_d;
      event_q <= event_d;
      fault_q <= fault_d;
      int_en_q <= int_en_d;
      slow_rc_q <= cfg_q.failure_detector_enable;
    end
  end

  // Read mux; sampled at the address phase so data stands from a flop
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (addr_lo)
      MAIN_OSC_REG_OFS: begin
        rdata_d[OSC_XTAL_EN_BIT] = cfg_q.crystal_osc_enable;
        rdata_d[OSC_RC_EN_BIT] = cfg_q.main_rc_enable;
        rdata_d[OSC_DET_EN_BIT] = cfg_q.failure_detector_enable;
        rdata_d[OSC_SEL_BIT] = cfg_q.main_source_select;
      end
      MASTER_CLK_REG_OFS: rdata_d[1:0] = cfg_q.master_source_select;
      POWER_STATUS_REG_OFS: begin
        rdata_d[SR_EVENT_BIT] = event_q;
        rdata_d[SR_FAULT_BIT] = fault_q;
        rdata_d[SR_STATE_BIT] = detect_state_q;
        rdata_d[SR_SLOW_RC_BIT] = slow_rc_q;
      end
      INT_ENABLE_REG_OFS: rdata_d[SR_EVENT_BIT] = int_en_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Bus state; zero wait states, so the data phase never stalls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= addr_lo;
      rdata_q <= rd_take ? rdata_d : 32'h0000_0000;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign clk_cfg = cfg_q;
  assign slow_rc_enable = slow_rc_q;
  assign fault_out = fault_q;
  assign irq = event_q & int_en_q;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cnt_clear;
    !rc_high |=> (cnt_q == 4'h0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("count not cleared while slow low");

  property p_verdict;
    (det_active && rc_fall && armed_q) |=> (verdict_q == ($past(cnt_q) < XTAL_MIN_COUNT));
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("verdict mismatches crystal count");

  property p_one_decision;
    fail_pulse |-> (rc_rise && !$past(rc_high));
  endproperty
  a_one_decision: assert property (p_one_decision)
    else $error("failure raised off slow edge");

  property p_off;
    (!cfg_q.crystal_osc_enable || !cfg_q.failure_detector_enable) |-> !fail_pulse;
  endproperty
  a_off: assert property (p_off)
    else $error("failure raised while detector off");

  property p_slow_rc;
    cfg_q.failure_detector_enable |=> slow_rc_enable;
  endproperty
  a_slow_rc: assert property (p_slow_rc)
    else $error("slow oscillator not enabled");

  property p_flags;
    fail_pulse |=> (event_q && fault_q && fault_out);
  endproperty
  a_flags: assert property (p_flags)
    else $error("failure did not set both flags");

  property p_read_clear;
    (rd_status && !fail_pulse) |=> !event_q;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read kept event flag");

  property p_fault_hold;
    (fault_q && !(wr_fclr && hwdata[FAULT_CLEAR_BIT])) |=> fault_q;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault status dropped by itself");

  property p_irq;
    irq |-> (event_q && int_en_q);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enabled event");

  property p_pll_switch;
    (fail_pulse && pll_route) |=> (clk_cfg.master_source_select == MSRC_MAIN) && pending_q;
  endproperty
  a_pll_switch: assert property (p_pll_switch)
    else $error("master clock not moved to main");

  property p_rc_switch;
    (fail_pulse && !pll_route) |=> (!clk_cfg.main_source_select && clk_cfg.main_rc_enable);
  endproperty
  a_rc_switch: assert property (p_rc_switch)
    else $error("main source not forced to rc");

  property p_pending;
    (pending_q && rc_rise) |=> (!pending_q && !clk_cfg.main_source_select);
  endproperty
  a_pending: assert property (p_pending)
    else $error("second switch step missing");

  property p_resync;
    $rose(event_q) |-> $past(rc_rise);
  endproperty
  a_resync: assert property (p_resync)
    else $error("event set off the slow edge");

  property p_cnt_step;
    (det_active && rc_high && xtal_rise && (cnt_q != XTAL_MIN_COUNT)) |=>
      (cnt_q == $past(cnt_q) + 4'h1);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("count did not follow a crystal edge");

  property p_partial;
    (det_active && rc_fall && !armed_q) |=> $stable(verdict_q);
  endproperty
  a_partial: assert property (p_partial)
    else $error("verdict taken from a partial high phase");

  property p_inactive;
    !det_active |=> (!armed_q && !verdict_q && !detect_state_q);
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("detector state kept while inactive");

  property p_event_cause;
    $rose(event_q) |-> $past(fail_pulse);
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("event flag set without a failure");

  property p_fault_clear;
    (wr_fclr && hwdata[FAULT_CLEAR_BIT] && !fail_pulse) |=> !fault_out;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault clear write had no effect");

  property p_irq_on;
    (event_q && int_en_q) |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled event did not raise interrupt");

  property p_fault_no_irq;
    (fault_q && !event_q) |-> !irq;
  endproperty
  a_fault_no_irq: assert property (p_fault_no_irq)
    else $error("fault status alone raised interrupt");

  property p_state_read;
    rd_status |=> (hrdata[SR_STATE_BIT] == $past(detect_state_q));
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("status read shows stale detection state");

  property p_pll_first;
    (fail_pulse && pll_route && !wr_osc) |=> clk_cfg.main_source_select;
  endproperty
  a_pll_first: assert property (p_pll_first)
    else $error("main source moved before master clock");

  property p_rc_on;
    (pending_q && rc_rise) |=> clk_cfg.main_rc_enable;
  endproperty
  a_rc_on: assert property (p_rc_on)
    else $error("main rc not enabled at switch");

  property p_fault_line;
    $rose(fault_out) |-> $past(fail_pulse);
  endproperty
  a_fault_line: assert property (p_fault_line)
    else $error("fault line raised without a failure");

  property p_rdata_idle;
    !rd_take |=> (hrdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data left on bus outside a read");

endmodule // ccfd_top

// >>> ccfd_top_test.sv
// Self-checking bench for the crystal clock failure detector
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module ccfd_top_test
  import ccfd_pkg::*;
;
  localparam int SLOW = 80;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] xtal_mode = 2'h1;
  logic hreadyout, hresp, xtal_clk_pin, slow_rc_clk_pin, slow_rc_enable, fault_out, irq;
  logic [31:0] hrdata;
  ccfd_cfg_s clk_cfg;
  int n_errors = 0;
  int total_checks = 0;
  // Reference model state
  int m_osc = 2;
  int m_msrc = 1;
  int m_ien = 0;
  int m_event = 0;
  int m_fault = 0;
  int m_state = 0;

  ccfd_top ccfd_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xtal_clk_pin(xtal_clk_pin),
    .slow_rc_clk_pin(slow_rc_clk_pin), .clk_cfg(clk_cfg), .slow_rc_enable(slow_rc_enable),
    .fault_out(fault_out), .irq(irq));
  ccfd_osc_model ccfd_osc_model_inst (.xtal_mode(xtal_mode), .slow_rc_enable(slow_rc_enable),
    .xtal_clk_pin(xtal_clk_pin), .slow_rc_clk_pin(slow_rc_clk_pin));

  always #25 hclk = ~hclk;

  // Expected register contents from the model
  function automatic int reg_exp(input logic [7:0] a);
    case (a)
      MAIN_OSC_REG_OFS: return m_osc;
      MASTER_CLK_REG_OFS: return m_msrc;
      POWER_STATUS_REG_OFS: return m_event | (m_fault << 1) | (m_state << 2) | (m_osc & 4) << 1;
      INT_ENABLE_REG_OFS: return m_ien;
      default: return 0;
    endcase
  endfunction

  // One AHB single transfer; caller enters just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rdat);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic rd(input logic [7:0] a);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    `CHK("hrdata", reg_exp(a), d)
    if (a == POWER_STATUS_REG_OFS) m_event = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, a, d, unused);
    case (a)
      MAIN_OSC_REG_OFS: m_osc = d[3:0];
      MASTER_CLK_REG_OFS: m_msrc = d[1:0];
      INT_ENABLE_REG_OFS: m_ien = d[0];
      FAULT_CLEAR_REG_OFS: if (d[0]) m_fault = 0;
      INT_CLEAR_REG_OFS: if (d[0]) m_event = 0;
      default: ;
    endcase
  endtask

  // Pin outputs against the model, after the last update has landed
  task automatic ports_chk();
    repeat (2) @(posedge hclk);
    `CHK("clk_cfg", {m_osc[0], m_osc[1], m_osc[2], m_osc[3], m_msrc[1:0]}, clk_cfg)
    `CHK("fault_out", m_fault[0], fault_out)
    `CHK("irq", m_event[0] & m_ien[0], irq)
    `CHK("slow_rc_enable", m_osc[2], slow_rc_enable)
  endtask

  // Forced switchover as the model sees it
  task automatic fail_model();
    if (m_osc[3] && m_msrc >= 2) m_msrc = 1;
    m_osc = (m_osc & 'h7) | 'h2;
    m_event = 1;
    m_fault = 1;
    m_state = 1;
  endtask

  // Bounded wait for the main source to leave the crystal
  task automatic wait_switch(input int lim);
    int n = 0;
    while (clk_cfg.main_source_select !== 1'b0 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    `CHK("switch delay", 1, n < lim)
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(69093));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 'h18; a += 4) rd(a[7:0]);
    ports_chk();
    repeat (4) begin
      wr(MASTER_CLK_REG_OFS, $urandom);
      wr(INT_ENABLE_REG_OFS, $urandom);
      rd(MASTER_CLK_REG_OFS);
      rd(INT_ENABLE_REG_OFS);
    end
    // Crystal disabled: detector stays quiet even with no crystal clock
    xtal_mode <= 2'h0;
    wr(MAIN_OSC_REG_OFS, 32'h6);
    repeat (4 * SLOW) @(posedge hclk);
    rd(POWER_STATUS_REG_OFS);
    ports_chk();
    xtal_mode <= 2'h1;
    wr(MAIN_OSC_REG_OFS, 32'hf);
    repeat (4 * SLOW) @(posedge hclk);
    rd(POWER_STATUS_REG_OFS);
    // Half-speed crystal: five periods per window, main RC off beforehand
    wr(MASTER_CLK_REG_OFS, 32'h1);
    wr(INT_ENABLE_REG_OFS, 32'h1);
    wr(MAIN_OSC_REG_OFS, 32'hd);
    xtal_mode <= 2'h2;
    wait_switch(2 * SLOW + 16);
    fail_model();
    ports_chk();
    rd(POWER_STATUS_REG_OFS);
    rd(POWER_STATUS_REG_OFS);
    ports_chk();
    wr(FAULT_CLEAR_REG_OFS, 32'h1);
    ports_chk();
    rd(POWER_STATUS_REG_OFS);
    xtal_mode <= 2'h1;
    m_state = 0;
    repeat (3 * SLOW) @(posedge hclk);
    rd(POWER_STATUS_REG_OFS);
    wr(INT_ENABLE_REG_OFS, 32'h0);
    // PLL sources: master forced back to main clock, interrupt masked
    for (int s = 2; s <= 3; s++) begin
      wr(MAIN_OSC_REG_OFS, 32'hd);
      wr(MASTER_CLK_REG_OFS, s);
      repeat (2 * SLOW) @(posedge hclk);
      xtal_mode <= 2'h0;
      wait_switch(3 * SLOW + 16);
      fail_model();
      ports_chk();
      if (s == 2) rd(POWER_STATUS_REG_OFS);
      else wr(INT_CLEAR_REG_OFS, 32'h1);
      wr(FAULT_CLEAR_REG_OFS, 32'h1);
      xtal_mode <= 2'h1;
      m_state = 0;
      repeat (3 * SLOW) @(posedge hclk);
      rd(POWER_STATUS_REG_OFS);
    end
    // Core reset in mid-run with the detector on: all back to reset values
    wr(INT_ENABLE_REG_OFS, 32'h1);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    m_osc = 2;
    m_msrc = 1;
    m_ien = 0;
    m_event = 0;
    m_fault = 0;
    m_state = 0;
    @(posedge hclk);
    for (int a = 0; a <= 'h0c; a += 4) rd(a[7:0]);
    ports_chk();
    final_report();
  end

  // Watchdog, well beyond the few thousand cycles the run needs
  initial begin
    repeat (12000) @(posedge hclk);
    n_errors++;
    final_report();
  end
endmodule // ccfd_top_test
